// ---- logic/bboe_execute.sv ----
`timescale 1ns/1ps
`default_nettype none
module bboe_execute
  import bboe_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic         instr_valid_in,
  input  wire bboe_instr_s  instr_in,
  input  wire logic [7:0]   memory_operand_in,
  output logic              instr_ready_out,
  output bboe_mem_wr_s      mem_wr_out,
  output logic [7:0]        primary_accumulator_out,
  output bboe_status_s      status_out,
  output logic [14:0]       program_counter_out,
  output logic              nop_cycle_out
);

  bboe_state_e       state_q, state_d;
  logic [7:0]        acc_q, acc_d;
  bboe_status_s      st_q, st_d;
  logic [14:0]       pc_q, pc_d;
  bboe_mem_wr_s      wr_q, wr_d;
  logic              nop_q;

  // Ports are fixed at byte, 7-bit address and 15-bit counter widths;
  // refuse a package edited to anything the datapath cannot serve
  if (DATA_W != 8 || ADDR_W != 7 || POS_W != 3 || OFS_W != 9 ||
      PC_W != 15 || MSB_BIT != DATA_W - 1 || NIB_BIT != 4) begin
    $error("package widths do not fit this datapath");
  end

  // Nine-bit sum so the carry out of bit 7 is kept
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic c);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, c};
  endfunction

  // Operation decode and arithmetic
  wire               take       = instr_valid_in && state_q == BBOE_ST_RUN;
  wire               is_add     = instr_in.op == BBOE_OP_ADD;
  wire               is_addc    = instr_in.op == BBOE_OP_ADDC;
  wire               is_asr     = instr_in.op == BBOE_OP_ASR;
  wire               is_clr     = instr_in.op == BBOE_OP_CLR;
  wire               is_tlow    = instr_in.op == BBOE_OP_TLOW;
  wire               is_thigh   = instr_in.op == BBOE_OP_THIGH;
  wire               is_branch  = instr_in.op == BBOE_OP_BRANCH;

  // A write-back lands in memory one edge late, so a back-to-back
  // instruction on the same address takes the value still in flight
  wire               fwd_hit    = wr_q.write_en &&
                                  wr_q.addr == instr_in.file_addr;
  wire logic [7:0]   opnd       = fwd_hit ? wr_q.data : memory_operand_in;

  // Carry in only for the carry-add form; the plain add ignores it
  wire               cin        = is_addc & st_q.arith_overflow_bit; // RULE_04
  wire logic [8:0]   sum        = add9(acc_q, opnd, cin); // RULE_01
  // Low nibbles summed alone; bit 4 of this sum is the nibble carry
  wire logic [8:0]   nib        = add9({4'h0, acc_q[3:0]},
                                       {4'h0, opnd[3:0]}, cin); // RULE_10
  wire logic [7:0]   asr_res    = {opnd[MSB_BIT], opnd[7:1]}; // RULE_03
  wire logic [7:0]   clr_mask   = ~(8'h01 << instr_in.position_index);
  wire logic [7:0]   clr_res    = opnd & clr_mask; // RULE_05
  wire               sel_bit    = opnd[instr_in.position_index];
  wire               skip       = (is_tlow && !sel_bit) || // RULE_06
                                  (is_thigh && sel_bit); // RULE_07
  wire logic [14:0]  pc_inc     = pc_q + 15'h0001;
  wire logic [14:0]  ofs_ext    = {{6{instr_in.signed_offset[8]}},
                                   instr_in.signed_offset}; // RULE_08
  wire               arith      = is_add | is_addc | is_asr;
  wire logic [7:0]   res        = is_asr ? asr_res : sum[7:0];

  // Next-state logic
  always_comb begin
    acc_d   = acc_q;
    st_d    = st_q;
    pc_d    = pc_q;
    wr_d    = '0;
    state_d = BBOE_ST_RUN;
    if (take) begin
      pc_d = pc_inc;
      if (is_add || is_addc) begin
        st_d.arith_overflow_bit  = sum[8]; // RULE_10
        st_d.nibble_overflow_bit = nib[NIB_BIT]; // RULE_10
      end
      if (is_asr)
        st_d.arith_overflow_bit = opnd[0]; // RULE_03
      if (arith)
        st_d.null_result_bit = res == 8'h00; // RULE_10
      if (arith && !instr_in.target_select)
        acc_d = res; // RULE_02
      if (arith && instr_in.target_select)
        wr_d = '{1'b1, instr_in.file_addr, res}; // RULE_02
      if (is_clr)
        wr_d = '{1'b1, instr_in.file_addr, clr_res}; // RULE_05
      if (skip) begin
        pc_d    = pc_q + 15'h0002; // RULE_06 RULE_07
        state_d = BBOE_ST_NOP; // RULE_09
      end
      if (is_branch) begin
        pc_d    = pc_inc + ofs_ext; // RULE_08
        state_d = BBOE_ST_NOP; // RULE_09
      end
    end
    case (state_q)
      BBOE_ST_RUN: ;
      BBOE_ST_NOP: ;
      default: state_d = BBOE_ST_RUN;
    endcase
  end

  // State registers
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= BBOE_ST_RUN;
      acc_q   <= ACC_RESET;
      st_q    <= '0;
      pc_q    <= PC_RESET;
      wr_q    <= '0;
      nop_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      st_q    <= st_d;
      pc_q    <= pc_d;
      wr_q    <= wr_d;
      // Pulse marks the slot that replaces the discarded instruction
      nop_q   <= state_q == BBOE_ST_RUN && state_d == BBOE_ST_NOP;
    end
  end

  // Decoder stalls one cycle while the no-operation slot runs
  assign instr_ready_out         = state_q == BBOE_ST_RUN; // RULE_09
  assign mem_wr_out              = wr_q;
  assign primary_accumulator_out = acc_q;
  assign status_out              = st_q;
  assign program_counter_out     = pc_q;
  assign nop_cycle_out           = nop_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  // Stall slot then release: the shape of every two-cycle instruction
  sequence two_cycle_s;
    instr_ready_out == 1'b0 ##1 instr_ready_out == 1'b1;
  endsequence

  // Additions, their flags and where their results go
  add_result_a: assert property ( // RULE_01
    take && is_add && !instr_in.target_select
      |=> acc_q == $past(acc_q + opnd) && !wr_q.write_en)
    else $error("add result wrong");
  target_mem_a: assert property ( // RULE_02
    take && arith && instr_in.target_select
      |=> wr_q.write_en && wr_q.data == $past(res) &&
          wr_q.addr == $past(instr_in.file_addr))
    else $error("write back missing");
  target_acc_a: assert property ( // RULE_02
    take && arith && instr_in.target_select |=> $stable(acc_q))
    else $error("accumulator disturbed");
  addc_carry_a: assert property ( // RULE_04
    take && is_addc |=> st_q.arith_overflow_bit ==
      ($past({1'b0, acc_q} + {1'b0, opnd} +
             {8'h00, st_q.arith_overflow_bit}) > 9'h0ff))
    else $error("carry add wrong");
  nibble_flag_a: assert property ( // RULE_10
    take && (is_add || is_addc) |=> st_q.nibble_overflow_bit ==
      ($past({1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin}) > 5'h0f))
    else $error("nibble carry wrong");

  // Signed shift keeps the sign bit and drops bit 0 into carry
  asr_carry_a: assert property ( // RULE_03
    take && is_asr |=> st_q.arith_overflow_bit == $past(opnd[0]))
    else $error("shift carry wrong");
  shift_msb_a: assert property ( // RULE_03
    take && is_asr && !instr_in.target_select
      |=> acc_q == $past({opnd[7], opnd[7:1]}))
    else $error("shift result wrong");

  // Bit clear touches one bit and nothing else
  clear_keeps_a: assert property ( // RULE_05
    take && is_clr |=> $stable(st_q) &&
      wr_q.data[$past(instr_in.position_index)] == 1'b0)
    else $error("bit clear wrong");
  clear_others_a: assert property ( // RULE_05
    take && is_clr
      |=> $countones(wr_q.data ^ $past(opnd)) <= 1 && $stable(acc_q))
    else $error("other bits disturbed");

  // Skips and branches: target, then one no-op slot
  skip_low_a: assert property ( // RULE_06
    take && is_tlow && !sel_bit |=> two_cycle_s)
    else $error("low skip missing");
  skip_high_a: assert property ( // RULE_07
    take && is_thigh && sel_bit |=> two_cycle_s and nop_q)
    else $error("high skip missing");
  skip_pc_a: assert property ( // RULE_06 RULE_07
    take && skip |=> pc_q == $past(pc_q) + 15'h0002)
    else $error("skip target wrong");
  branch_pc_a: assert property ( // RULE_08
    take && is_branch |=> $stable(st_q) && pc_q == $past(pc_q) + 15'h0001 +
      $past(15'(signed'(instr_in.signed_offset))))
    else $error("branch target wrong");
  branch_slot_a: assert property ( // RULE_08
    take && is_branch |=> two_cycle_s and nop_q)
    else $error("branch slot missing");

  // Single-cycle ops never stall; the no-op slot changes nothing
  no_skip_a: assert property ( // RULE_09
    take && !skip && !is_branch |=> instr_ready_out)
    else $error("spurious stall");
  nop_frozen_a: assert property ( // RULE_09
    state_q == BBOE_ST_NOP |=> $stable(pc_q) && $stable(acc_q) &&
      $stable(st_q) && !wr_q.write_en)
    else $error("no-op slot not idle");
  zero_flag_a: assert property ( // RULE_10
    take && arith
      |=> st_q.null_result_bit == ($past(res) == 8'h00))
    else $error("zero flag wrong");
endmodule
`default_nettype wire

// ---- logic/bboe_pkg.sv ----
// Functional notes
// RULE_01: add accumulator and operand at file address 0..127; update carry, nibble, zero.
// RULE_02: target select 0 writes accumulator, 1 writes result back to operand.
// RULE_03: signed shift right keeps bit 7; old bit 0 to carry; zero updated.
// RULE_04: add with carry sums accumulator, operand and carry; all three flags updated.
// RULE_05: clear chosen bit 0..7 of operand; other bits and flags untouched.
// RULE_06: skip-if-low discards next instruction when bit is zero; two cycles.
// RULE_07: skip-if-high discards next instruction when bit is one; two cycles.
// RULE_08: relative branch adds sign-extended 9-bit offset to incremented counter; no flags.
// RULE_09: counter change or true test takes two cycles, second is no-operation.
// RULE_10: carry from bit 7, nibble carry from bit 3, zero when result zero.
package bboe_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned POS_W    = 3;
  localparam int unsigned OFS_W    = 9;
  localparam int unsigned PC_W     = 15;
  localparam int unsigned NIB_BIT  = 4;
  localparam int unsigned MSB_BIT  = 7;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

  typedef enum logic [2:0] {
    BBOE_OP_NONE  = 3'b000,
    BBOE_OP_ADD   = 3'b001,
    BBOE_OP_ADDC  = 3'b010,
    BBOE_OP_ASR   = 3'b011,
    BBOE_OP_CLR   = 3'b100,
    BBOE_OP_TLOW  = 3'b101,
    BBOE_OP_THIGH = 3'b110,
    BBOE_OP_BRANCH = 3'b111
  } bboe_op_e;

  typedef enum logic [0:0] {
    BBOE_ST_RUN = 1'b0,
    BBOE_ST_NOP = 1'b1
  } bboe_state_e;

  // One decoded instruction from the decoder
  typedef struct packed {
    bboe_op_e          op;
    logic [ADDR_W-1:0] file_addr;
    logic              target_select;
    logic [POS_W-1:0]  position_index;
    logic [OFS_W-1:0]  signed_offset;
  } bboe_instr_s;

  // Write back toward data memory
  typedef struct packed {
    logic              write_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bboe_mem_wr_s;

  typedef struct packed {
    logic arith_overflow_bit;
    logic nibble_overflow_bit;
    logic null_result_bit;
  } bboe_status_s;
endpackage

// ---- test/bboe_data_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// Data memory beside the block: combinational read, written on the clock
module bboe_data_mem
  import bboe_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic [6:0]   addr_in,
  input  wire bboe_mem_wr_s wr_in,
  output logic [7:0]        data_out
);
  logic [7:0] mem_q [128];
  // Seeded so that every read returns a known, varied value
  initial for (int i = 0; i < 128; i++) mem_q[i] = 8'(i * 59) ^ 8'h5a;
  assign data_out = mem_q[addr_in];
  // Write-back lands one edge after the pulse rises, as in real memory
  always @(posedge clock_in) begin
    if (wr_in.write_en) mem_q[wr_in.addr] <= wr_in.data;
  end
endmodule
`default_nettype wire

// ---- test/test_byte_bit_op_execute.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_byte_bit_op_execute
  import bboe_pkg::*;
;
  logic         clock_in = 1'b0;
  logic         reset_n_in = 1'b0;
  logic         instr_valid_in = 1'b0;
  bboe_instr_s  instr_in = '0;
  wire logic [7:0] memory_operand_in;
  logic         instr_ready_out, nop_cycle_out;
  bboe_mem_wr_s mem_wr_out;
  logic [7:0]   primary_accumulator_out, e_acc = 8'h00;
  bboe_status_s status_out, e_st = '0;
  logic [14:0]  program_counter_out, e_pc = 15'h0000;
  logic [31:0]  seed = 32'h7e51;
  int           num_errors = 0;
  int           tests_run = 0;
  logic         w_last = 1'b0;
  logic [14:0]  wr_last = '0;
  wire logic [22:0] acc_pc = {primary_accumulator_out, program_counter_out};
`define CHK(n, e, g) begin tests_run++; \
  if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

  always #5 clock_in = ~clock_in;

  bboe_execute i_bboe_execute (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .memory_operand_in(memory_operand_in), .instr_ready_out(instr_ready_out),
    .mem_wr_out(mem_wr_out), .primary_accumulator_out(primary_accumulator_out),
    .status_out(status_out), .program_counter_out(program_counter_out),
    .nop_cycle_out(nop_cycle_out));
  bboe_data_mem i_bboe_data_mem (.clock_in(clock_in),
    .addr_in(instr_in.file_addr), .wr_in(mem_wr_out),
    .data_out(memory_operand_in));

  // Random source, repeatable from its fixed start value
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One instruction from a falling edge; expectations from a local model
  task automatic issue(input bboe_op_e op, input logic [6:0] a, input logic t,
                       input logic [2:0] b, input logic [8:0] k);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] m, r;
    logic       c, two, wexp;
    instr_in = '{op, a, t, b, k};
    instr_valid_in = 1'b1;
    // Operand as memory shows it, or the write still on its way there
    #1;
    m = w_last && wr_last[14:8] == a ? wr_last[7:0] : memory_operand_in;
    @(posedge clock_in);
    c = (op == BBOE_OP_ADDC) & e_st.arith_overflow_bit;
    two = 1'b0;
    wexp = 1'b0;
    r = m;
    e_pc = e_pc + 15'h0001;
    case (op)
      BBOE_OP_ADD, BBOE_OP_ADDC: begin
        s = e_acc + m + c;
        h = e_acc[3:0] + m[3:0] + c;
        r = s[7:0];
        e_st.arith_overflow_bit = s[8];
        e_st.nibble_overflow_bit = h[4];
      end
      BBOE_OP_ASR: begin
        r = {m[7], m[7:1]};
        e_st.arith_overflow_bit = m[0];
      end
      BBOE_OP_CLR: begin
        r[b] = 1'b0;
        wexp = 1'b1;
      end
      BBOE_OP_TLOW: two = !m[b];
      BBOE_OP_THIGH: two = m[b];
      BBOE_OP_BRANCH: begin
        two = 1'b1;
        e_pc = e_pc + {{6{k[8]}}, k};
      end
      default: ;
    endcase
    if (two && op != BBOE_OP_BRANCH) e_pc = e_pc + 15'h0001;
    if (op inside {BBOE_OP_ADD, BBOE_OP_ADDC, BBOE_OP_ASR}) begin
      e_st.null_result_bit = (r == 8'h00);
      if (t) wexp = 1'b1;
      else e_acc = r;
    end
    @(negedge clock_in);
    `CHK("acc", e_acc, primary_accumulator_out)
    `CHK("status", e_st, status_out)
    `CHK("pc", e_pc, program_counter_out)
    `CHK("write", wexp, mem_wr_out.write_en)
    `CHK("nop", two, nop_cycle_out)
    `CHK("ready", !two, instr_ready_out)
    if (wexp) `CHK("wdata", {a, r}, {mem_wr_out.addr, mem_wr_out.data})
    // Stale request stays valid through the no-op slot and must be refused
    if (two) begin
      @(negedge clock_in);
      `CHK("refused", {e_acc, e_pc}, acc_pc)
      `CHK("resume", 1'b1, instr_ready_out)
    end
    w_last = wexp;
    wr_last = {a, r};
  endtask

  initial begin
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    reset_n_in = 1'b1;
    `CHK("reset", 23'h000000, acc_pc)
    // Every operation once, then both branch range ends
    for (int i = 0; i < 8; i++) begin
      issue(bboe_op_e'(i), 7'(i * 9), i[0], 3'(7 - i), 9'h100);
    end
    issue(BBOE_OP_BRANCH, 7'h7f, 1'b0, 3'h0, 9'h0ff);
    // Back to back on one address: each sees the write just before it
    issue(BBOE_OP_ADD, 7'h05, 1'b1, 3'h0, 9'h000);
    issue(BBOE_OP_ASR, 7'h05, 1'b1, 3'h0, 9'h000);
    issue(BBOE_OP_CLR, 7'h05, 1'b0, 3'h7, 9'h000);
    issue(BBOE_OP_THIGH, 7'h05, 1'b0, 3'h7, 9'h000);
    // Decoder idle for a cycle: nothing may move
    instr_valid_in = 1'b0;
    @(negedge clock_in);
    w_last = 1'b0;
    `CHK("idle", {e_acc, e_pc}, acc_pc)
    `CHK("idle write", 1'b0, mem_wr_out.write_en)
    $display("test corners done");
    repeat (400) begin
      seed = lfsr(seed);
      issue(bboe_op_e'(seed[2:0]), seed[9:3], seed[10], seed[13:11], seed[22:14]);
    end
    $display("test random done");
    conclude();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
